// ===== dcs_pkg.sv
package dcs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] DCS_ADDR_STATUS   = 4'h0;
    localparam logic [3:0] DCS_ADDR_IRQ_EN   = 4'h1;
    localparam logic [3:0] DCS_ADDR_IRQ_CLR  = 4'h2;
    localparam logic [3:0] DCS_ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] DCS_ADDR_LOG      = 4'h4;

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int DCS_BIT_DONE = 0;
    localparam int DCS_BIT_BUSY = 1;
    localparam int DCS_BIT_REQ  = 2;
    localparam int DCS_BIT_BED  = 4;
    localparam int DCS_BIT_BES  = 5;
    localparam int DCS_BIT_CE   = 6;

    // Interrupt event positions
    localparam int DCS_EV_DONE = 0;
    localparam int DCS_EV_CE   = 1;
    localparam int DCS_EV_BES  = 2;
    localparam int DCS_EV_BED  = 3;
    localparam int DCS_EV_NUM  = 4;

    // ------------------------------------------------------------------
    // Reset values and log sizing
    // ------------------------------------------------------------------
    localparam logic [7:0] DCS_STATUS_RST = 8'h00;
    localparam logic [3:0] DCS_IRQ_EN_RST = 4'h0;
    localparam int         DCS_LOG_DEPTH  = 16;
    localparam int         DCS_LOG_AW     = 4;

    // Transfer sizes: 00 long, 01 byte, 10 word, 11 line (16 bytes)
    typedef enum logic [1:0] {
        DCS_SZ_LONG = 2'b00,
        DCS_SZ_BYTE = 2'b01,
        DCS_SZ_WORD = 2'b10,
        DCS_SZ_LINE = 2'b11
    } dcs_size_e;

    typedef enum logic [1:0] {
        DCS_ST_IDLE,
        DCS_ST_WAIT,
        DCS_ST_ACTIVE
    } dcs_state_e;

endpackage

// ===== dcs_log_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Small event log: last status snapshots taken at each channel end
module dcs_log_mem
    import dcs_pkg::*;
(
    input  wire logic                  mclk,     // System clock
    input  wire logic                  wr_en,    // Write strobe
    input  wire logic [DCS_LOG_AW-1:0] wr_addr,  // Write index
    input  wire logic [7:0]            wr_data,  // Write value
    input  wire logic [DCS_LOG_AW-1:0] rd_addr,  // Read index
    output logic      [7:0]            rd_data   // Registered read value
);
    logic [7:0] mem [DCS_LOG_DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ===== dcs_channel_status.sv
// Contract
// - Configuration error is set when the byte count does not fit the source or destination size.
// - Configuration error is also set when source or destination address is misaligned for its size.
// - Configuration error is cleared by reset or by writing one to the done bit.
// - Source bus error is set when the channel ends on a bus error in the read phase.
// - Destination bus error is set when the channel ends on a bus error in the write phase.
// - Request reads one while work remains and the channel is not selected.
// - Request clears when the channel is selected and stays zero while active or idle.
// - Busy is set the first time the channel is enabled after a transfer starts.
// - Busy clears once the channel finishes its last transaction.
// - Done is set when the byte count reaches zero and the last transfer ends without error.
// - Writing one to done clears every status flag, errors and interrupt state included.
// - Writing one to done during a transfer aborts it and resets the status flags.
// - Writing zero to done has no effect at all.
// - The clear action from a done write releases by itself with no further write.
// - A one at bit 0 makes a one-cycle channel reset pulse; other status bits ignore writes.
`timescale 1ns/1ps
`default_nettype none
module dcs_channel_status
    import dcs_pkg::*;
(
    input  wire logic        mclk,          // 20 MHz system clock
    input  wire logic        nrst,          // Async reset, active low
    input  wire logic [3:0]  reg_addr,      // Register index
    input  wire logic [7:0]  reg_wdata,     // Write data
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic        reg_rd,        // Read strobe
    output logic      [7:0]  reg_rdata,     // Read data, cycle after strobe
    input  wire logic        xfer_start,    // Pulse: transfer initiated
    input  wire logic        chan_enabled,  // Level: channel enabled
    input  wire logic        chan_selected, // Level: channel granted the bus
    input  wire logic [23:0] byte_count,    // Remaining byte count
    input  wire logic [31:0] source_address,      // Source address
    input  wire logic [31:0] destination_address, // Destination address
    input  wire logic [1:0]  src_size,      // Source transfer size
    input  wire logic [1:0]  dst_size,      // Destination transfer size
    input  wire logic        xfer_last,     // Pulse: final transaction concluded
    input  wire logic        bus_err_rd,    // Pulse: bus error in read phase
    input  wire logic        bus_err_wr,    // Pulse: bus error in write phase
    output logic             chan_reset,    // One-cycle channel reset / abort
    output logic             chan_halt,     // Level: stop transfers on error
    output logic             irq            // Level interrupt
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dcs_state_e            state;
        logic                  ce;
        logic                  source_bus_error_flag;
        logic                  bed;
        logic                  busy;
        logic                  done;
        logic                  reset_pulse;
        logic [DCS_EV_NUM-1:0] irq_stat;
        logic [DCS_EV_NUM-1:0] irq_en;
        logic [7:0]            rdata;
        logic                  rd_log;
        logic [DCS_LOG_AW-1:0] log_ptr;
    } dcs_state_s;

    dcs_state_s s_reg;
    dcs_state_s s_next;

    logic [7:0]            status;
    logic                  req;
    logic                  cfg_bad;
    logic                  done_wr;
    logic [DCS_EV_NUM-1:0] ev;
    logic                  log_wr;
    logic [7:0]            log_rdata;

    // ------------------------------------------------------------------
    // Configuration checks
    // ------------------------------------------------------------------
    function automatic logic misfit(input logic [1:0] sz, input logic [3:0] low);
        logic r;
        r = 1'b0;
        case (sz)
            DCS_SZ_BYTE: r = 1'b0;
            DCS_SZ_WORD: r = low[0];
            DCS_SZ_LONG: r = |low[1:0];
            DCS_SZ_LINE: r = |low[3:0];
            default:     r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        cfg_bad = misfit(src_size, byte_count[3:0])
                | misfit(dst_size, byte_count[3:0])
                | misfit(src_size, source_address[3:0])
                | misfit(dst_size, destination_address[3:0]);
    end

    // Software done write: only bit 0 of the status register acts
    assign done_wr = reg_wr && (reg_addr == DCS_ADDR_STATUS)
                     && reg_wdata[DCS_BIT_DONE];

    // Request derives from live state so it tracks selection exactly
    assign req = (s_reg.state == DCS_ST_WAIT) && !chan_selected;

    always_comb begin
        status               = 8'h00;
        status[DCS_BIT_CE]   = s_reg.ce;
        status[DCS_BIT_BES]  = s_reg.source_bus_error_flag;
        status[DCS_BIT_BED]  = s_reg.bed;
        status[DCS_BIT_REQ]  = req;
        status[DCS_BIT_BUSY] = s_reg.busy;
        status[DCS_BIT_DONE] = s_reg.done;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next             = s_reg;
        s_next.reset_pulse = done_wr;
        s_next.rd_log      = 1'b0;
        ev                 = '0;
        log_wr             = 1'b0;

        case (s_reg.state)
            DCS_ST_IDLE: begin
                if (xfer_start) begin
                    s_next.state = DCS_ST_WAIT;
                end
            end
            DCS_ST_WAIT: begin
                if (chan_enabled) begin
                    s_next.busy = 1'b1;
                end
                if (chan_selected) begin
                    s_next.state = DCS_ST_ACTIVE;
                end
            end
            DCS_ST_ACTIVE: begin
                if (bus_err_rd || bus_err_wr) begin
                    s_next.source_bus_error_flag   = s_reg.source_bus_error_flag | bus_err_rd;
                    s_next.bed   = s_reg.bed | bus_err_wr;
                    s_next.busy  = 1'b0;
                    s_next.state = DCS_ST_IDLE;
                    ev[DCS_EV_BES] = bus_err_rd;
                    ev[DCS_EV_BED] = bus_err_wr;
                    log_wr       = 1'b1;
                end else if (xfer_last && byte_count == 24'h000000) begin
                    s_next.done  = 1'b1;
                    s_next.busy  = 1'b0;
                    s_next.state = DCS_ST_IDLE;
                    ev[DCS_EV_DONE] = 1'b1;
                    log_wr       = 1'b1;
                end else if (!chan_selected) begin
                    s_next.state = DCS_ST_WAIT;
                end
            end
            default: begin
                s_next.state = DCS_ST_IDLE;
            end
        endcase

        // Checked while a transfer is pending or running
        if (s_reg.state != DCS_ST_IDLE && cfg_bad) begin
            s_next.ce     = 1'b1;
            ev[DCS_EV_CE] = !s_reg.ce;
            if (!s_reg.ce) begin
                s_next.state = DCS_ST_IDLE;
                s_next.busy  = 1'b0;
                log_wr       = 1'b1;
            end
        end

        // ------------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------------
        if (reg_wr && reg_addr == DCS_ADDR_IRQ_EN) begin
            s_next.irq_en = reg_wdata[DCS_EV_NUM-1:0];
        end
        if (reg_wr && reg_addr == DCS_ADDR_IRQ_CLR) begin
            s_next.irq_stat = s_reg.irq_stat & ~reg_wdata[DCS_EV_NUM-1:0];
        end
        if (log_wr) begin
            s_next.log_ptr = s_reg.log_ptr + 1'b1;
        end

        // Done write clears all status flags and pending interrupts (irq_en kept) and aborts; new events in the
        // same cycle are dropped, since the channel is being reset anyway
        if (done_wr) begin
            s_next.ce       = 1'b0;
            s_next.source_bus_error_flag      = 1'b0;
            s_next.bed      = 1'b0;
            s_next.busy     = 1'b0;
            s_next.done     = 1'b0;
            s_next.irq_stat = '0;
            s_next.state    = DCS_ST_IDLE;
        end else begin
            // Set wins over a simultaneous clear-register write
            s_next.irq_stat = s_next.irq_stat | ev;
        end

        // ------------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------------
        s_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                DCS_ADDR_STATUS:   s_next.rdata = status;
                DCS_ADDR_IRQ_EN:   s_next.rdata = {4'h0, s_reg.irq_en};
                DCS_ADDR_IRQ_STAT: s_next.rdata = {4'h0, s_reg.irq_stat};
                DCS_ADDR_LOG:      s_next.rd_log = 1'b1;
                default:           s_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg.state       <= DCS_ST_IDLE;
            s_reg.ce          <= 1'b0;
            s_reg.source_bus_error_flag         <= 1'b0;
            s_reg.bed         <= 1'b0;
            s_reg.busy        <= 1'b0;
            s_reg.done        <= 1'b0;
            s_reg.reset_pulse <= 1'b0;
            s_reg.irq_stat    <= '0;
            s_reg.irq_en      <= DCS_IRQ_EN_RST;
            s_reg.rdata       <= 8'h00;
            s_reg.rd_log      <= 1'b0;
            s_reg.log_ptr     <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Snapshot log of status at each channel end
    // ------------------------------------------------------------------
    // Entry holds the flags as they settle at the channel end; the read
    // index trails the write pointer so software sees the newest entry
    dcs_log_mem u_log (
        .mclk    (mclk),
        .wr_en   (log_wr),
        .wr_addr (s_reg.log_ptr),
        .wr_data ({1'b0, s_next.ce, s_next.source_bus_error_flag, s_next.bed,
                   2'b00, s_next.busy, s_next.done}),
        .rd_addr (s_reg.log_ptr - 1'b1),
        .rd_data (log_rdata)
    );

    assign reg_rdata  = s_reg.rd_log ? log_rdata : s_reg.rdata;
    assign chan_reset = s_reg.reset_pulse;
    assign chan_halt  = s_reg.ce | s_reg.source_bus_error_flag | s_reg.bed;
    assign irq        = |(s_reg.irq_stat & s_reg.irq_en);
endmodule
`default_nettype wire

// ===== dcs_channel_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_channel_status_asserts
    import dcs_pkg::*;
(
    input wire logic       mclk,       // System clock
    input wire logic       nrst,       // Async reset, active low
    input wire logic [3:0] reg_addr,   // Register index
    input wire logic [7:0] reg_wdata,  // Write data
    input wire logic       reg_wr,     // Write strobe
    input wire logic       reg_rd,     // Read strobe
    input wire logic [7:0] reg_rdata,  // Read data
    input wire logic       bus_err_rd, // Read phase bus error
    input wire logic       bus_err_wr, // Write phase bus error
    input wire logic       chan_reset, // Channel reset pulse
    input wire logic       chan_halt,  // Error halt level
    input wire logic       irq         // Interrupt level
);
    logic done_wr;

    assign done_wr = reg_wr && reg_addr == DCS_ADDR_STATUS && reg_wdata[DCS_BIT_DONE];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence pulse_s;
        chan_reset ##1 !chan_reset;
    endsequence

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data present without a read");
    reset_cause_a: assert property (done_wr |=> pulse_s)
        else $error("done write gave no single reset pulse");
    reset_only_a: assert property (chan_reset |-> $past(done_wr))
        else $error("reset pulse without a done write");
    reset_clears_a: assert property (chan_reset |=> !irq && !chan_halt)
        else $error("flags survive the channel reset");
    halt_hold_a: assert property (chan_halt && !chan_reset && !done_wr |=> chan_halt)
        else $error("error flag dropped without a done write");
    halt_err_a: assert property (bus_err_rd || bus_err_wr |-> ##[1:2] chan_halt)
        else $error("bus error did not halt the channel");
    reserved_zero_a: assert property (reg_rd && reg_addr == DCS_ADDR_STATUS |=>
        reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("reserved status bit reads one");
    wo_clear_a: assert property (reg_rd && (reg_addr == DCS_ADDR_IRQ_CLR ||
        reg_addr > DCS_ADDR_LOG) |=> reg_rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
endmodule

bind dcs_channel_status dcs_channel_status_asserts i_chk (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_err_rd(bus_err_rd),
    .bus_err_wr(bus_err_wr), .chan_reset(chan_reset), .chan_halt(chan_halt), .irq(irq)
);
`default_nettype wire

// ===== dcs_channel_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end
module dcs_channel_status_bench;
    import dcs_pkg::*;
    logic        mclk, nrst, reg_wr, reg_rd, xfer_start, chan_enabled, chan_selected;
    logic        xfer_last, bus_err_rd, bus_err_wr, chan_reset, chan_halt, irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rd_val;
    logic [23:0] byte_count;
    logic [31:0] source_address, destination_address;
    logic [1:0]  src_size, dst_size;
    int          num_errors, tests_run;

    dcs_channel_status i_dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_start(xfer_start),
        .chan_enabled(chan_enabled), .chan_selected(chan_selected), .byte_count(byte_count),
        .source_address(source_address), .destination_address(destination_address),
        .src_size(src_size), .dst_size(dst_size), .xfer_last(xfer_last),
        .bus_err_rd(bus_err_rd), .bus_err_wr(bus_err_wr), .chan_reset(chan_reset),
        .chan_halt(chan_halt), .irq(irq)
    );

    always #25 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Bus and engine helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic run_to_active();
        @(posedge mclk);
        xfer_start    <= 1'b1;
        @(posedge mclk);
        xfer_start    <= 1'b0;
        chan_enabled  <= 1'b1;
        chan_selected <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic last_beat();
        @(posedge mclk);
        xfer_last  <= 1'b1;
        byte_count <= 24'h00_0000;
        @(posedge mclk);
        xfer_last  <= 1'b0;
        byte_count <= 24'h00_0010;
    endtask

    // Done write must wipe flags, interrupt and halt in one go
    task automatic clr_chk();
        @(posedge mclk);
        chan_enabled  <= 1'b0;
        chan_selected <= 1'b0;
        wr(DCS_ADDR_STATUS, 8'h01);
        #1 `CHK(chan_reset, 1'b1)
        rd(DCS_ADDR_STATUS);
        `CHK(chan_reset, 1'b0)
        `CHK(rd_val, 8'h00)
        `CHK(irq, 1'b0)
        `CHK(chan_halt, 1'b0)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_done();
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, DCS_STATUS_RST)
        @(posedge mclk);
        xfer_start <= 1'b1;
        @(posedge mclk);
        xfer_start <= 1'b0;
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h04)
        @(posedge mclk);
        chan_enabled <= 1'b1;
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h06)
        @(posedge mclk);
        chan_selected <= 1'b1;
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h02)
        last_beat();
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h01)
        `CHK(irq, 1'b0)
        wr(DCS_ADDR_IRQ_EN, 8'h01);
        rd(DCS_ADDR_IRQ_STAT);
        `CHK(rd_val, 8'h01)
        `CHK(irq, 1'b1)
        wr(DCS_ADDR_IRQ_CLR, 8'h01);
        rd(DCS_ADDR_IRQ_CLR);
        `CHK(rd_val, 8'h00)
        `CHK(irq, 1'b0)
        wr(DCS_ADDR_STATUS, 8'hFE);
        #1 `CHK(chan_reset, 1'b0)
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h01)
        clr_chk();
        $display("test done-and-clear complete");
    endtask

    task automatic t_err();
        wr(DCS_ADDR_IRQ_EN, 8'h0F);
        for (int i = 0; i < 2; i++) begin
            run_to_active();
            bus_err_rd <= (i == 0);
            bus_err_wr <= (i == 1);
            @(posedge mclk);
            bus_err_rd <= 1'b0;
            bus_err_wr <= 1'b0;
            rd(DCS_ADDR_STATUS);
            `CHK(rd_val & 8'h70, (i == 1) ? 8'h10 : 8'h20)
            `CHK(irq, 1'b1)
            rd(DCS_ADDR_IRQ_STAT);
            `CHK(rd_val, (i == 1) ? 8'h08 : 8'h04)
            rd(DCS_ADDR_LOG);
            `CHK(rd_val, (i == 1) ? 8'h10 : 8'h20)
            clr_chk();
        end
        $display("test bus-error complete");
    endtask

    // Cases: misaligned source, bad count for word, misaligned line destination
    task automatic t_cfg();
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            source_address      <= (k == 0) ? 32'h0000_0102 : 32'h0000_0100;
            byte_count          <= (k == 1) ? 24'h00_0003 : 24'h00_0010;
            dst_size            <= (k == 1) ? DCS_SZ_WORD : (k == 2) ? DCS_SZ_LINE : DCS_SZ_LONG;
            destination_address <= (k == 2) ? 32'h0000_0108 : 32'h0000_0100;
            run_to_active();
            rd(DCS_ADDR_STATUS);
            `CHK(rd_val & 8'h40, 8'h40)
            `CHK(chan_halt, 1'b1)
            rd(DCS_ADDR_LOG);
            `CHK(rd_val, 8'h40)
            clr_chk();
        end
        @(posedge mclk);
        destination_address <= 32'h0000_0100;
        dst_size            <= DCS_SZ_LONG;
        $display("test config-error complete");
    endtask

    task automatic t_abort();
        run_to_active();
        clr_chk();
        last_beat();
        rd(DCS_ADDR_STATUS);
        `CHK(rd_val, 8'h00)
        wr(DCS_ADDR_IRQ_EN, 8'hFF);
        rd(DCS_ADDR_IRQ_EN);
        `CHK(rd_val & 8'h0F, 8'h0F)
        rd(4'hF);
        `CHK(rd_val, 8'h00)
        $display("test abort-and-map complete");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;       nrst = 1'b0;          reg_addr = 4'h0;   reg_wdata = 8'h00;
        reg_wr = 1'b0;     reg_rd = 1'b0;        xfer_start = 1'b0; chan_enabled = 1'b0;
        chan_selected = 1'b0; xfer_last = 1'b0;  bus_err_rd = 1'b0; bus_err_wr = 1'b0;
        byte_count = 24'h00_0010; source_address = 32'h0000_0100;
        destination_address = 32'h0000_0100; src_size = DCS_SZ_LONG; dst_size = DCS_SZ_LONG;
        num_errors = 0;    tests_run = 0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_done();
        t_err();
        t_cfg();
        t_abort();
        conclude();
    end

    // Whole run needs under two hundred cycles; allow ample margin
    initial begin
        #(50 * 4000);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
